// [sync_dram_ctrl_cfg.sv]
// SDRAM command spacing and geometry configuration with AXI4-Lite access
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sync_dram_ctrl_cfg (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [3:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [3:0]  araddr,
  input  wire logic [2:0]  arprot,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_kind,
  input  wire logic [31:0] cmd_addr,
  output logic             cmd_accept,
  output logic             mem_cmd_strobe,
  output logic [2:0]       mem_cmd_kind,
  output logic [1:0]       mem_bank,
  output logic [12:0]      mem_row,
  output logic [7:0]       mem_col,
  output logic [1:0]       cas_cycles,
  output logic             mem_bus_16
);

  // ---------------------------------------------------------------
  // Configuration fields
  // ---------------------------------------------------------------
  logic [31:0] cfg;
  logic [3:0]  precharge_delay;
  logic [3:0]  row_and_refresh_cycle_delay;
  logic [3:0]  write_recovery_delay;
  logic        memory_bus_width_select;
  logic [1:0]  cas_select;
  logic        bank_count_select;
  logic [1:0]  row_width_select;

  assign precharge_delay   = cfg[sync_dram_pkg::PRECHARGE_LSB +: 4];
  assign row_and_refresh_cycle_delay = cfg[sync_dram_pkg::ROW_REFR_LSB +: 4];
  assign write_recovery_delay = cfg[sync_dram_pkg::WRITE_REC_LSB +: 4];
  assign memory_bus_width_select = cfg[sync_dram_pkg::BUS_WIDTH_BIT];
  assign cas_select        = cfg[sync_dram_pkg::CAS_LSB +: 2];
  assign bank_count_select = cfg[sync_dram_pkg::BANK_COUNT_BIT];
  assign row_width_select  = cfg[sync_dram_pkg::ROW_WIDTH_LSB +: 2];

  // Byte-lane merge; illegal CAS or reserved row codes keep the old value
  function automatic logic [31:0] merge_cfg(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
    logic [31:0] lanes;
    logic [31:0] res;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    lanes = lanes & sync_dram_pkg::CFG_WMASK;
    res   = (old & ~lanes) | (data & lanes);
    if (res[sync_dram_pkg::CAS_LSB +: 2] < sync_dram_pkg::cas_two_cycles) begin
      res[sync_dram_pkg::CAS_LSB +: 2] = old[sync_dram_pkg::CAS_LSB +: 2];
    end
    if (res[sync_dram_pkg::ROW_WIDTH_LSB +: 2] ==
        sync_dram_pkg::ROW_RESERVED) begin
      res[sync_dram_pkg::ROW_WIDTH_LSB +: 2] =
        old[sync_dram_pkg::ROW_WIDTH_LSB +: 2];
    end
    return res;
  endfunction : merge_cfg

  // Split a 16-bit-wide byte address into {bank, row, column}
  function automatic logic [22:0] split_addr(input logic [31:0] addr,
                                             input logic        four,
                                             input logic [1:0]  rows);
    logic [31:0] upper;
    logic [12:0] row;
    logic [1:0]  bank;
    upper = four ? (addr >> 11) : (addr >> 10);
    bank  = four ? addr[10:9] : {1'b0, addr[9]};
    case (rows)
      sync_dram_pkg::rows_eleven_bits:  row = {2'b00, upper[10:0]};
      sync_dram_pkg::rows_twelve_bits:  row = {1'b0, upper[11:0]};
      default:                          row = upper[12:0];
    endcase
    return {bank, row, addr[8:1]};
  endfunction : split_addr

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  logic        aw_full;
  logic        w_full;
  logic [3:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        aw_take;
  logic        w_take;
  logic        commit;
  logic [3:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        next_aw_full;
  logic        next_w_full;

  assign aw_take = awvalid & awready;
  assign w_take  = wvalid & wready;
  // A new answer waits until the previous one is collected
  assign commit  = (aw_full | aw_take) & (w_full | w_take) & ~bvalid;
  assign wr_addr = aw_full ? aw_addr_q : awaddr;
  assign wr_data = w_full ? w_data_q : wdata;
  assign wr_strb = w_full ? w_strb_q : wstrb;
  assign next_aw_full = (aw_full | aw_take) & ~commit;
  assign next_w_full  = (w_full | w_take) & ~commit;

  // Address and data taken in either order, held until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full   <= 1'b0;
      w_full    <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
    end else begin
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      awready <= ~next_aw_full;
      wready  <= ~next_w_full;
      if (aw_take) begin
        aw_addr_q <= awaddr;
      end
      if (w_take) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
    end
  end

  // Write response; status writes are ignored, other offsets refused
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= sync_dram_pkg::RESP_OKAY;
    end else if (commit) begin
      bvalid <= 1'b1;
      bresp  <= (wr_addr == sync_dram_pkg::CFG_OFFSET ||
                 wr_addr == sync_dram_pkg::STATUS_OFFSET) ?
                sync_dram_pkg::RESP_OKAY : sync_dram_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Configuration register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= sync_dram_pkg::CFG_RESET;
    end else if (commit && wr_addr == sync_dram_pkg::CFG_OFFSET) begin
      cfg <= merge_cfg(cfg, wr_data, wr_strb);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  logic        ar_take;
  logic [31:0] status;
  logic        pre_busy;
  logic        rc_busy;
  logic        wr_busy;

  assign ar_take = arvalid & arready;
  assign status  = {25'h0, mem_cmd_kind, wr_busy, rc_busy, pre_busy,
                    cmd_valid & ~cmd_accept};

  // One read in flight; answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= sync_dram_pkg::RESP_OKAY;
    end else begin
      arready <= ~(ar_take | (rvalid & ~rready));
      if (ar_take) begin
        rvalid <= 1'b1;
        case (araddr)
          sync_dram_pkg::CFG_OFFSET: begin
            rdata <= cfg;
            rresp <= sync_dram_pkg::RESP_OKAY;
          end
          sync_dram_pkg::STATUS_OFFSET: begin
            rdata <= status;
            rresp <= sync_dram_pkg::RESP_OKAY;
          end
          default: begin
            rdata <= 32'h0;
            rresp <= sync_dram_pkg::RESP_SLVERR;
          end
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Command spacing
  // ---------------------------------------------------------------
  logic     blocked;
  logic     issue;
  logic     is_pre;
  logic     is_row;
  logic     is_wr;

  assign is_pre = (cmd_kind == sync_dram_pkg::CMD_PRECHARGE);
  assign is_row = (cmd_kind == sync_dram_pkg::CMD_ACTIVATE) ||
                  (cmd_kind == sync_dram_pkg::CMD_REFRESH);
  assign is_wr  = (cmd_kind == sync_dram_pkg::CMD_WRITE);
  assign blocked = pre_busy | (rc_busy & is_row) | (wr_busy & is_pre);
  // The accept pulse guard stops one held request being taken twice
  assign issue = cmd_valid & ~cmd_accept & ~blocked;

  gap_timer u_pre_gap (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (issue & is_pre),
    .gap     (precharge_delay),
    .busy    (pre_busy)
  );

  gap_timer u_rc_gap (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (issue & is_row),
    .gap     (row_and_refresh_cycle_delay),
    .busy    (rc_busy)
  );

  gap_timer u_wr_gap (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (issue & is_wr),
    .gap     (write_recovery_delay),
    .busy    (wr_busy)
  );

  // Command outputs with address split by current geometry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_accept     <= 1'b0;
      mem_cmd_strobe <= 1'b0;
      mem_cmd_kind   <= 3'h0;
      mem_bank       <= 2'h0;
      mem_row        <= 13'h0;
      mem_col        <= 8'h0;
    end else begin
      cmd_accept     <= issue;
      mem_cmd_strobe <= issue;
      if (issue) begin
        mem_cmd_kind <= cmd_kind;
        {mem_bank, mem_row, mem_col} <=
          split_addr(cmd_addr, bank_count_select, row_width_select);
      end
    end
  end

  // Geometry seen by the pad logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cas_cycles <= sync_dram_pkg::cas_two_cycles;
      mem_bus_16 <= sync_dram_pkg::CFG_RESET[sync_dram_pkg::BUS_WIDTH_BIT];
    end else begin
      cas_cycles <= cas_select;
      mem_bus_16 <= memory_bus_width_select;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [4:0] since_pre;
  logic [4:0] since_row;
  logic [4:0] since_wr;
  logic       seen_pre;
  logic       seen_row;
  logic       seen_wr;

  // Cycles since the last command of each class, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_pre <= 5'h0;
      since_row <= 5'h0;
      since_wr  <= 5'h0;
      seen_pre  <= 1'b0;
      seen_row  <= 1'b0;
      seen_wr   <= 1'b0;
    end else begin
      since_pre <= (since_pre == 5'h1f) ? since_pre : since_pre + 5'h1;
      since_row <= (since_row == 5'h1f) ? since_row : since_row + 5'h1;
      since_wr  <= (since_wr == 5'h1f) ? since_wr : since_wr + 5'h1;
      if (mem_cmd_strobe &&
          mem_cmd_kind == sync_dram_pkg::CMD_PRECHARGE) begin
        since_pre <= 5'h0;
        seen_pre  <= 1'b1;
      end
      if (mem_cmd_strobe && (mem_cmd_kind == sync_dram_pkg::CMD_ACTIVATE ||
          mem_cmd_kind == sync_dram_pkg::CMD_REFRESH)) begin
        since_row <= 5'h0;
        seen_row  <= 1'b1;
      end
      if (mem_cmd_strobe && mem_cmd_kind == sync_dram_pkg::CMD_WRITE) begin
        since_wr <= 5'h0;
        seen_wr  <= 1'b1;
      end
    end
  end

  property p_precharge_gap;
    @(posedge aclk) disable iff (!aresetn)
      mem_cmd_strobe && seen_pre |-> since_pre >= {1'b0, precharge_delay};
  endproperty
  a_precharge_gap: assert property (p_precharge_gap)
    else $error("command too soon after precharge");

  property p_row_gap;
    @(posedge aclk) disable iff (!aresetn)
      mem_cmd_strobe && seen_row &&
      (mem_cmd_kind == sync_dram_pkg::CMD_ACTIVATE ||
       mem_cmd_kind == sync_dram_pkg::CMD_REFRESH)
      |-> since_row >= {1'b0, row_and_refresh_cycle_delay};
  endproperty
  a_row_gap: assert property (p_row_gap)
    else $error("activate or refresh too soon");

  property p_write_recovery;
    @(posedge aclk) disable iff (!aresetn)
      mem_cmd_strobe && seen_wr &&
      mem_cmd_kind == sync_dram_pkg::CMD_PRECHARGE
      |-> since_wr >= {1'b0, write_recovery_delay};
  endproperty
  a_write_recovery: assert property (p_write_recovery)
    else $error("precharge too soon after write");

  // Output is the stored bit, one cycle late, in every cycle
  property p_bus_width;
    @(posedge aclk) disable iff (!aresetn)
      mem_bus_16 == $past(memory_bus_width_select);
  endproperty
  a_bus_width: assert property (p_bus_width)
    else $error("bus width output does not follow its bit");

  property p_cas_legal;
    @(posedge aclk) disable iff (!aresetn)
      cas_cycles == sync_dram_pkg::cas_two_cycles ||
      cas_cycles == sync_dram_pkg::cas_three_cycles;
  endproperty
  a_cas_legal: assert property (p_cas_legal)
    else $error("unsupported CAS latency");

  property p_two_banks;
    @(posedge aclk) disable iff (!aresetn)
      issue && bank_count_select == sync_dram_pkg::two_banks
      |=> mem_bank[1] == 1'b0;
  endproperty
  a_two_banks: assert property (p_two_banks)
    else $error("bank above range for two banks");

  property p_row_width;
    @(posedge aclk) disable iff (!aresetn)
      issue && row_width_select == sync_dram_pkg::rows_eleven_bits
      |=> mem_row[12:11] == 2'h0 && row_width_select != 2'h3;
  endproperty
  a_row_width: assert property (p_row_width)
    else $error("row above range for eleven row bits");

  property p_column_split;
    @(posedge aclk) disable iff (!aresetn)
      issue |=> mem_cmd_strobe && mem_col == $past(cmd_addr[8:1]);
  endproperty
  a_column_split: assert property (p_column_split)
    else $error("column not taken from the address");

endmodule : sync_dram_ctrl_cfg
`default_nettype wire

// [sync_dram_pkg.sv]
// Shared constants and types for the SDRAM timing and geometry block
`default_nettype none
package sync_dram_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0]  CFG_OFFSET    = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET = 4'h4;
  localparam logic [31:0] CFG_RESET     = 32'h0003_72c0;
  localparam logic [31:0] CFG_WMASK     = 32'h000f_fffc;

  // ---------------------------------------------------------------
  // Field positions in the configuration word
  // ---------------------------------------------------------------
  localparam int PRECHARGE_LSB  = 16;
  localparam int ROW_REFR_LSB   = 12;
  localparam int WRITE_REC_LSB  = 8;
  localparam int BUS_WIDTH_BIT  = 7;
  localparam int CAS_LSB        = 5;
  localparam int BANK_COUNT_BIT = 4;
  localparam int ROW_WIDTH_LSB  = 2;

  // ---------------------------------------------------------------
  // Field encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] cas_two_cycles     = 2'h2;
  localparam logic [1:0] cas_three_cycles   = 2'h3;
  localparam logic       two_banks          = 1'b0;
  localparam logic       four_banks         = 1'b1;
  localparam logic [1:0] rows_eleven_bits   = 2'h0;
  localparam logic [1:0] rows_twelve_bits   = 2'h1;
  localparam logic [1:0] rows_thirteen_bits = 2'h2;
  localparam logic [1:0] ROW_RESERVED       = 2'h3;

  // ---------------------------------------------------------------
  // Address geometry and bus answers
  // ---------------------------------------------------------------
  localparam int         COL_BITS    = 8;
  localparam int         ROW_BITS    = 13;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CMD_ACTIVATE,
    CMD_READ,
    CMD_WRITE,
    CMD_PRECHARGE,
    CMD_REFRESH
  } mem_cmd_e;

endpackage : sync_dram_pkg
`default_nettype wire

// [gap_timer.sv]
// Down-counter that holds off commands for a programmed number of cycles
`timescale 1ns/1ps
`default_nettype none
module gap_timer (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       load,
  input  wire logic [3:0] gap,
  output logic            busy
);

  logic [3:0] remaining;

  // Reload on each command, then count down to idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remaining <= 4'h0;
    end else if (load) begin
      remaining <= gap;
    end else if (remaining != 4'h0) begin
      remaining <= remaining - 4'h1;
    end
  end

  assign busy = (remaining != 4'h0);

endmodule : gap_timer
`default_nettype wire

// [sdram_cmd_model.sv]
// Far-side SDRAM model that measures idle cycles between commands
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       mem_cmd_strobe,
  output logic      [7:0] last_gap
);
  // ---------------------------------------------------------------
  // Command spacing seen at the memory
  // ---------------------------------------------------------------
  logic [7:0] idle;

  // Saturates so a long quiet stretch never wraps into a short gap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle     <= 8'hff;
      last_gap <= 8'hff;
    end else if (mem_cmd_strobe) begin
      last_gap <= idle;
      idle     <= 8'h00;
    end else if (idle != 8'hff) begin
      idle <= idle + 8'h01;
    end
  end
endmodule : sdram_cmd_model
`default_nettype wire

// [test_sync_dram_ctrl_cfg.sv]
// Self-checking bench for the SDRAM timing and geometry block
`timescale 1ns/1ps
`default_nettype none
module test_sync_dram_ctrl_cfg;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, cmd_valid;
  logic        cmd_accept, mem_cmd_strobe, mem_bus_16;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [2:0]  awprot, arprot, cmd_kind, mem_cmd_kind;
  logic [31:0] wdata, rdata, cmd_addr;
  logic [1:0]  bresp, rresp, mem_bank, cas_cycles;
  logic [12:0] mem_row;
  logic [7:0]  mem_col, last_gap;
  int          errors, n_compared;

  sync_dram_ctrl_cfg uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_accept(cmd_accept),
    .mem_cmd_strobe(mem_cmd_strobe), .mem_cmd_kind(mem_cmd_kind),
    .mem_bank(mem_bank), .mem_row(mem_row), .mem_col(mem_col),
    .cas_cycles(cas_cycles), .mem_bus_16(mem_bus_16));

  sdram_cmd_model model (.aclk(aclk), .aresetn(aresetn),
    .mem_cmd_strobe(mem_cmd_strobe), .last_gap(last_gap));

  // 250 MHz clock
  always #2 aclk = ~aclk;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  // Bit 7 always one: only the narrow bus is supported
  function automatic logic [31:0] cfgw(input int pre, row, wr, cas, bk, rc);
    return 32'((pre << 16) | (row << 12) | (wr << 8) | (1 << 7)
               | (cas << 5) | (bk << 4) | (rc << 2));
  endfunction : cfgw

  // Each channel is released on its own handshake; response ends it
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    bit done;
    done = 0;
    r = 2'h1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // The answer on bvalid ends the wait; only the watchdog ends one that never comes
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    bit done;
    done = 0;
    r = 2'h1;
    d = 32'h0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        r = rresp;
        d = rdata;
        rready <= 1'b0;
        done = 1;
      end
    end
    @(posedge aclk);
  endtask : axi_rd

  // Request held until accepted, then dropped for at least one cycle
  task automatic issue(input logic [2:0] k, input logic [31:0] a);
    bit got;
    got = 0;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_valid <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (cmd_accept === 1'b1) begin
        got = 1;
        cmd_valid <= 1'b0;
        check(32'(mem_cmd_strobe), 32'h1);
        check(32'(mem_cmd_kind), 32'(k));
      end
    end
    @(posedge aclk);
  endtask : issue

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(sync_dram_pkg::CFG_OFFSET, d, r);
    check(d, cfgw(3, 7, 2, 2, 0, 0));
    check(32'(cas_cycles), 32'h2);
    check(32'(mem_bus_16), 32'h1);
  endtask : t_reset

  // Unmapped places refuse; the status word ignores writes
  task automatic t_map;
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(4'h8, d, r);
    check(32'(r), 32'(sync_dram_pkg::RESP_SLVERR));
    check(d, 32'h0);
    axi_wr(4'hc, 32'h0, r);
    check(32'(r), 32'(sync_dram_pkg::RESP_SLVERR));
    axi_wr(sync_dram_pkg::STATUS_OFFSET, 32'hffff_ffff, r);
    check(32'(r), 32'(sync_dram_pkg::RESP_OKAY));
    axi_rd(sync_dram_pkg::CFG_OFFSET, d, r);
    check(d, cfgw(3, 7, 2, 2, 0, 0));
  endtask : t_map

  // Reserved CAS and row codes leave the old setting in place
  task automatic t_fields;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(sync_dram_pkg::CFG_OFFSET, cfgw(3, 7, 2, 3, 1, 1), r);
    check(32'(cas_cycles), 32'h3);
    axi_wr(sync_dram_pkg::CFG_OFFSET, cfgw(3, 7, 2, 0, 1, 3), r);
    axi_rd(sync_dram_pkg::CFG_OFFSET, d, r);
    check(d, cfgw(3, 7, 2, 3, 1, 1));
    check(32'(cas_cycles), 32'h3);
  endtask : t_fields

  task automatic t_geom;
    logic [31:0] a, rw;
    logic [1:0]  r;
    a = 32'h3cf5_a6b6;
    for (int bk = 0; bk < 2; bk++) begin
      for (int rc = 0; rc < 3; rc++) begin
        axi_wr(sync_dram_pkg::CFG_OFFSET, cfgw(3, 7, 2, 2, bk, rc), r);
        issue(sync_dram_pkg::CMD_ACTIVATE, a);
        rw = (a >> (10 + bk)) & ((32'h1 << (11 + rc)) - 32'h1);
        check(32'(mem_row), rw);
        check(32'(mem_bank), bk ? 32'(a[10:9]) : 32'(a[9]));
        check(32'(mem_col), 32'(a[8:1]));
      end
    end
    check(32'(cas_cycles), 32'h2);
  endtask : t_geom

  task automatic t_gaps;
    logic [31:0] d;
    int          rowd;
    logic [1:0]  r;
    rowd = (6 > 5) ? 6 : 5;
    axi_wr(sync_dram_pkg::CFG_OFFSET, cfgw(5, rowd, 4, 2, 1, 0), r);
    issue(sync_dram_pkg::CMD_WRITE, 32'h0);
    issue(sync_dram_pkg::CMD_PRECHARGE, 32'h0);
    check(32'(last_gap), 32'd4);
    issue(sync_dram_pkg::CMD_READ, 32'h0);
    check(32'(last_gap), 32'd5);
    issue(sync_dram_pkg::CMD_ACTIVATE, 32'h0);
    issue(sync_dram_pkg::CMD_ACTIVATE, 32'h0);
    check(32'(last_gap), 32'(rowd));
    issue(sync_dram_pkg::CMD_REFRESH, 32'h0);
    check(32'(last_gap), 32'(rowd));
    issue(sync_dram_pkg::CMD_ACTIVATE, 32'h0);
    check(32'(last_gap), 32'(rowd));
    // A read is not held off by the row timer
    issue(sync_dram_pkg::CMD_READ, 32'h0);
    check(32'(last_gap), 32'd2);
    axi_wr(sync_dram_pkg::CFG_OFFSET, cfgw(15, rowd, 4, 2, 1, 0), r);
    issue(sync_dram_pkg::CMD_PRECHARGE, 32'h0);
    issue(sync_dram_pkg::CMD_ACTIVATE, 32'h0);
    check(32'(last_gap), 32'd15);
    // Row timer still running, last kind activate, nothing waiting
    axi_rd(sync_dram_pkg::STATUS_OFFSET, d, r);
    check(d, 32'h4);
    check(32'(r), 32'(sync_dram_pkg::RESP_OKAY));
  endtask : t_gaps

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {cmd_valid, awaddr, araddr, awprot, arprot, cmd_kind} = '0;
    {wdata, cmd_addr} = '0;
    wstrb = 4'hf;
    errors = 0;
    n_compared = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_map();
    t_fields();
    t_geom();
    t_gaps();
    conclude();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    conclude();
  end
endmodule : test_sync_dram_ctrl_cfg
`default_nettype wire
